// [hdl/ouc_global_cfg.sv]
// global configuration window and interrupt aggregation of the octal uart
// Function
// - configuration registers decode at 0x80 to 0x8F on the host bus.
// - eight channels occupy consecutive 16-byte windows, channel 0 lowest.
// - first eight locations of each channel window keep the classic layout.
// - summary register has one bit per channel, set while it requests service.
// - summary bit clears after reading the status register removing its cause.
// - three locator bytes hold 3-bit codes, channel N at bits 3N..3N+2.
// - summary and all locator bytes read zero after reset.
// - with several causes pending, the highest priority code is reported.
// - code zero means nothing pending or a sleep wake-up indication.
// - code 1 is receive level or line error; drain or line read clears.
// - code 2 is receive time-out, cleared by draining the receive queue.
// - code 3 is transmit ready, cleared by reading interrupt status.
// - code 4 is modem change, flow or special character event.
// - code 7 is timer time-out, channel 0 only, cleared by command read.
// - channel causes are gated by that channel's own enable register.
// - timer and wake interrupts are masked by timer command and sleep enable.
// - wake interrupt only when all eight channels had been put to sleep.
// - two per-channel bit registers choose 16x, 8x or 4x sampling.
// - write-only per-channel soft reset; broadcast bit writes all channels.
// - read-only identification code and silicon revision registers.
// - unenabled wake-up still interrupts, reads as none, clears on status read.
// - timer command reads 0x01 while a timer interrupt pends, else 0x00.
`timescale 1ns/1ns
module ouc_global_cfg
   import ouc_pkg::*;
#(
   parameter logic [7:0] DEV_IDENT   = 8'hA5,
   parameter logic [7:0] SILICON_REV = 8'h01
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  bus_rd,
   input  wire logic                  bus_wr,
   input  wire logic [7:0]            bus_addr,
   input  wire logic [7:0]            bus_wdata,
   output logic [7:0]                 bus_rdata,
   output logic [7:0]                 chan_sel,
   output logic                       chan_rd,
   output logic                       chan_wr,
   output logic [3:0]                 chan_index,
   output logic                       chan_compat,
   output logic [7:0]                 chan_wdata,
   input  wire logic [7:0][7:0]       chan_rdata,
   input  wire ouc_chan_stat_t [7:0]  chan_stat,
   input  wire ouc_chan_en_t [7:0]    chan_en,
   input  wire logic                  timer_timeout,
   output logic [3:0]                 timer_cmd,
   output logic                       timer_cmd_stb,
   output logic [15:0]                timer_count,
   output logic [7:0]                 eighth_rate_sel,
   output logic [7:0]                 quarter_rate_sel,
   output logic [7:0]                 chan_soft_reset,
   output logic [7:0]                 sleep_enable,
   output logic                       irq
);
   // arbitrary identification value above; not tied to any real part

   ouc_cfg_state_t  st;
   ouc_cfg_state_t  next_st;
   logic            cfg_hit;
   logic            chan_hit;
   logic [2:0]      chan_num;
   logic [7:0]      win_sel;
   logic [7:0]      isr_rd;
   logic [7:0]      lsr_rd;
   logic [7:0]      msr_rd;
   logic            sleep_all;
   logic            timer_rd;
   logic            timer_set;
   logic [7:0]      req_now;
   logic [23:0]     src_now;
   ouc_pend_t [7:0] pend;

   // address decode
   assign cfg_hit  = bus_addr[7:4] == CFG_BASE[7:4];
   assign chan_hit = ~bus_addr[7];
   assign chan_num = bus_addr[6:4];
   assign win_sel  = 8'h01 << chan_num;

   // channel window pass-through; broadcast bit widens writes
   always_comb
   begin
      chan_sel = 8'h00;
      if (chan_hit & bus_wr & st.bcast)
      begin
         chan_sel = 8'hFF;
      end
      else if (chan_hit & (bus_rd | bus_wr))
      begin
         chan_sel = win_sel;
      end
   end

   assign chan_rd     = chan_hit & bus_rd;
   assign chan_wr     = chan_hit & bus_wr;
   assign chan_index  = bus_addr[3:0];
   assign chan_compat = bus_addr[3:0] < CHAN_COMPAT_N;
   assign chan_wdata  = bus_wdata;

   // clear-on-read strobes towards the cause latches
   assign isr_rd    = (chan_rd && chan_index == CHAN_ISR_IDX) ? win_sel : 8'h00;
   assign lsr_rd    = (chan_rd && chan_index == CHAN_LSR_IDX) ? win_sel : 8'h00;
   assign msr_rd    = (chan_rd && chan_index == CHAN_MSR_IDX) ? win_sel : 8'h00;
   assign sleep_all = st.sleep_en == SLEEP_ALL;
   assign timer_rd  = bus_rd && bus_addr == OFF_TIMER_CMD;
   assign timer_set = timer_timeout & st.timer_irq_en;

   // per-channel latches and encoders
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_chan
         ouc_cause_latch u_latch
         (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .soft_rst  (st.soft_rst[g]),
            .stat      (chan_stat[g]),
            .en        (chan_en[g]),
            .isr_rd    (isr_rd[g]),
            .lsr_rd    (lsr_rd[g]),
            .msr_rd    (msr_rd[g]),
            .sleep_all (sleep_all),
            .pend      (pend[g])
         );
         ouc_src_encode #(
            .IS_CH0 (g == 0)
         ) u_enc
         (
            .pend       (pend[g]),
            .timer_pend (st.timer_pend),
            .code       (src_now[3*g +: 3]),
            .request    (req_now[g])
         );
      end
   endgenerate

   // register file
   always_comb
   begin
      next_st               = st;
      next_st.timer_cmd_stb = 1'b0;
      next_st.soft_rst      = 8'h00;
      next_st.summary       = req_now;
      next_st.src           = src_now;
      next_st.irq           = |req_now;
      next_st.timer_pend    = (st.timer_pend & ~timer_rd) | timer_set;
      if (bus_wr & cfg_hit)
      begin
         unique case (bus_addr)
            OFF_TIMER_CMD:
            begin
               next_st.timer_cmd     = bus_wdata[3:0];
               next_st.timer_cmd_stb = 1'b1;
               if (bus_wdata[3:0] == TCMD_IRQ_EN)
               begin
                  next_st.timer_irq_en = 1'b1;
               end
               else if (bus_wdata[3:0] == TCMD_IRQ_DIS)
               begin
                  next_st.timer_irq_en = 1'b0;
               end
            end
            OFF_TCNT_LOW:  next_st.timer_count[7:0]  = bus_wdata;
            OFF_TCNT_HIGH: next_st.timer_count[15:8] = bus_wdata;
            OFF_EIGHTH:    next_st.eighth            = bus_wdata;
            OFF_QUARTER:   next_st.quarter           = bus_wdata;
            OFF_SOFT_RST:  next_st.soft_rst          = bus_wdata;
            OFF_SLEEP:     next_st.sleep_en          = bus_wdata;
            OFF_BCAST:     next_st.bcast             = bus_wdata[BCAST_BIT];
            default:       next_st.rdata             = st.rdata;
         endcase
      end
      if (bus_rd & chan_hit)
      begin
         next_st.rdata = chan_rdata[chan_num];
      end
      else if (bus_rd & cfg_hit)
      begin
         unique case (bus_addr)
            OFF_SUMMARY:   next_st.rdata = st.summary;
            OFF_SRC_LOW:   next_st.rdata = st.src[7:0];
            OFF_SRC_MID:   next_st.rdata = st.src[15:8];
            OFF_SRC_HIGH:  next_st.rdata = st.src[23:16];
            OFF_TIMER_CMD: next_st.rdata = {7'h00, st.timer_pend};
            OFF_TCNT_LOW:  next_st.rdata = st.timer_count[7:0];
            OFF_TCNT_HIGH: next_st.rdata = st.timer_count[15:8];
            OFF_EIGHTH:    next_st.rdata = st.eighth;
            OFF_QUARTER:   next_st.rdata = st.quarter;
            OFF_SLEEP:     next_st.rdata = st.sleep_en;
            OFF_REVISION:  next_st.rdata = SILICON_REV;
            OFF_IDENT:     next_st.rdata = DEV_IDENT;
            OFF_BCAST:     next_st.rdata = {7'h00, st.bcast};
            default:       next_st.rdata = RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign bus_rdata        = st.rdata;
   assign timer_cmd        = st.timer_cmd;
   assign timer_cmd_stb    = st.timer_cmd_stb;
   assign timer_count      = st.timer_count;
   assign eighth_rate_sel  = st.eighth;
   assign quarter_rate_sel = st.quarter;
   assign chan_soft_reset  = st.soft_rst;
   assign sleep_enable     = st.sleep_en;
   assign irq              = st.irq;

   // checks
   irq_follows_a: assert property (@(posedge clk_sys) disable iff (rst)
      (|req_now) |=> irq ##0 (st.summary != 8'h00))
      else $error("interrupt output did not follow summary");

   reset_zero_a: assert property (@(posedge clk_sys)
      rst |=> (st.summary == 8'h00) && (st.src == 24'h000000) && !irq)
      else $error("interrupt registers not zero after reset");

   timer_only_ch0_a: assert property (@(posedge clk_sys) disable iff (rst)
      st.timer_pend && !(|st.summary[7:1]) |-> st.src[23:3] != {7{SRC_TIMER}})
      else $error("timer code seen outside channel 0");

   timer_readback_a: assert property (@(posedge clk_sys) disable iff (rst)
      (bus_rd && bus_addr == OFF_TIMER_CMD) |=> bus_rdata == {7'h00, $past(st.timer_pend)})
      else $error("timer command readback wrong");

   timer_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      (timer_rd && !timer_timeout) |=> !st.timer_pend ##1 (st.src[2:0] != SRC_TIMER))
      else $error("timer interrupt not cleared by read");

   timer_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!st.timer_pend && !st.timer_irq_en) |=> !st.timer_pend)
      else $error("masked timer interrupt became pending");

   chan_decode_a: assert property (@(posedge clk_sys) disable iff (rst)
      (bus_rd && !bus_addr[7]) |-> chan_sel == (8'h01 << bus_addr[6:4]))
      else $error("channel window decode wrong");

   rate_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      (bus_wr && bus_addr == OFF_EIGHTH) |=> eighth_rate_sel == $past(bus_wdata))
      else $error("eighth rate register not written");

   soft_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      (bus_wr && bus_addr == OFF_SOFT_RST) |=> chan_soft_reset == $past(bus_wdata)
      ##1 chan_soft_reset == 8'h00)
      else $error("soft reset not a single pulse");

   bcast_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      (bus_wr && !bus_addr[7] && st.bcast) |-> chan_sel == 8'hFF)
      else $error("broadcast write missed a channel");

   code_none_a: assert property (@(posedge clk_sys) disable iff (rst)
      (st.summary[0] == 1'b0) |-> st.src[2:0] == SRC_NONE)
      else $error("source code set without summary bit");

   ident_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      (bus_rd && bus_addr == OFF_IDENT) |=> bus_rdata == DEV_IDENT)
      else $error("identification read wrong");
endmodule // ouc_global_cfg

// [hdl/ouc_pkg.sv]
// shared constants and carrier types of the octal uart global config block
package ouc_pkg;
   localparam logic [7:0] CFG_BASE       = 8'h80;
   localparam logic [7:0] OFF_SUMMARY    = 8'h80;
   localparam logic [7:0] OFF_SRC_LOW    = 8'h81;
   localparam logic [7:0] OFF_SRC_MID    = 8'h82;
   localparam logic [7:0] OFF_SRC_HIGH   = 8'h83;
   localparam logic [7:0] OFF_TIMER_CMD  = 8'h84;
   localparam logic [7:0] OFF_TIMER_SPR  = 8'h85;
   localparam logic [7:0] OFF_TCNT_LOW   = 8'h86;
   localparam logic [7:0] OFF_TCNT_HIGH  = 8'h87;
   localparam logic [7:0] OFF_EIGHTH     = 8'h88;
   localparam logic [7:0] OFF_QUARTER    = 8'h89;
   localparam logic [7:0] OFF_SOFT_RST   = 8'h8A;
   localparam logic [7:0] OFF_SLEEP      = 8'h8B;
   localparam logic [7:0] OFF_REVISION   = 8'h8C;
   localparam logic [7:0] OFF_IDENT      = 8'h8D;
   localparam logic [7:0] OFF_BCAST      = 8'h8E;
   localparam logic [3:0] CHAN_ISR_IDX   = 4'h2;
   localparam logic [3:0] CHAN_LSR_IDX   = 4'h5;
   localparam logic [3:0] CHAN_MSR_IDX   = 4'h6;
   localparam logic [3:0] CHAN_COMPAT_N  = 4'h8;
   localparam logic [2:0] SRC_NONE       = 3'h0;
   localparam logic [2:0] SRC_RX         = 3'h1;
   localparam logic [2:0] SRC_RX_TOUT    = 3'h2;
   localparam logic [2:0] SRC_TX         = 3'h3;
   localparam logic [2:0] SRC_MODEM      = 3'h4;
   localparam logic [2:0] SRC_TIMER      = 3'h7;
   localparam logic [3:0] TCMD_IRQ_EN    = 4'h1;
   localparam logic [3:0] TCMD_IRQ_DIS   = 4'h2;
   localparam logic [7:0] SLEEP_ALL      = 8'hFF;
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam int         BCAST_BIT      = 0;

   typedef struct packed {
      logic rx_level;
      logic rx_timeout;
      logic line_err;
      logic tx_empty;
      logic modem_delta;
      logic special_evt;
      logic wake_evt;
      logic wake_covered;
   } ouc_chan_stat_t;

   typedef struct packed {
      logic rx_en;
      logic line_en;
      logic tx_en;
      logic modem_en;
   } ouc_chan_en_t;

   typedef struct packed {
      logic rx_level;
      logic rx_timeout;
      logic line;
      logic tx;
      logic modem;
      logic special;
      logic wake;
   } ouc_pend_t;

   typedef struct packed {
      logic line;
      logic tx;
      logic tx_prev;
      logic modem;
      logic special;
      logic wake;
   } ouc_latch_state_t;

   typedef struct packed {
      logic [7:0]  rdata;
      logic [7:0]  summary;
      logic [23:0] src;
      logic        irq;
      logic        timer_pend;
      logic        timer_irq_en;
      logic [3:0]  timer_cmd;
      logic        timer_cmd_stb;
      logic [15:0] timer_count;
      logic [7:0]  eighth;
      logic [7:0]  quarter;
      logic [7:0]  soft_rst;
      logic [7:0]  sleep_en;
      logic        bcast;
   } ouc_cfg_state_t;
endpackage

// [hdl/ouc_cause_latch.sv]
// per-channel interrupt cause latches with clear-on-read
`timescale 1ns/1ns
module ouc_cause_latch
   import ouc_pkg::*;
(
   input  wire logic           clk_sys,
   input  wire logic           rst,
   input  wire logic           soft_rst,
   input  wire ouc_chan_stat_t stat,
   input  wire ouc_chan_en_t   en,
   input  wire logic           isr_rd,
   input  wire logic           lsr_rd,
   input  wire logic           msr_rd,
   input  wire logic           sleep_all,
   output ouc_pend_t           pend
);
   ouc_latch_state_t st;
   ouc_latch_state_t next_st;

   always_comb
   begin
      next_st         = st;
      next_st.tx_prev = stat.tx_empty;
      // set wins over read clear below; soft reset wins over set
      next_st.line    = (st.line & ~lsr_rd) | (stat.line_err & en.line_en);
      next_st.tx      = (st.tx & ~isr_rd) | (stat.tx_empty & ~st.tx_prev & en.tx_en);
      next_st.modem   = (st.modem & ~msr_rd) | (stat.modem_delta & en.modem_en);
      next_st.special = (st.special & ~isr_rd) | (stat.special_evt & en.modem_en);
      next_st.wake    = (st.wake & ~isr_rd)
                      | (stat.wake_evt & sleep_all & ~stat.wake_covered);
      if (soft_rst)
      begin
         next_st = '0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign pend.rx_level   = stat.rx_level & en.rx_en;
   assign pend.rx_timeout = stat.rx_timeout & en.rx_en;
   assign pend.line       = st.line;
   assign pend.tx         = st.tx;
   assign pend.modem      = st.modem;
   assign pend.special    = st.special;
   assign pend.wake       = st.wake;
endmodule // ouc_cause_latch

// [hdl/ouc_src_encode.sv]
// per-channel priority encoder of the 3-bit source code
`timescale 1ns/1ns
module ouc_src_encode
   import ouc_pkg::*;
#(
   parameter bit IS_CH0 = 1'b0
)
(
   input  wire ouc_pend_t  pend,
   input  wire logic       timer_pend,
   output logic [2:0]      code,
   output logic            request
);
   logic timer_here;

   assign timer_here = IS_CH0 & timer_pend;

   always_comb
   begin
      if (pend.rx_level | pend.line)
      begin
         code = SRC_RX;
      end
      else if (pend.rx_timeout)
      begin
         code = SRC_RX_TOUT;
      end
      else if (pend.tx)
      begin
         code = SRC_TX;
      end
      else if (pend.modem | pend.special)
      begin
         code = SRC_MODEM;
      end
      else if (timer_here)
      begin
         code = SRC_TIMER;
      end
      else
      begin
         code = SRC_NONE;
      end
   end

   assign request = (code != SRC_NONE) | pend.wake;
endmodule // ouc_src_encode

// [test/ouc_host_model.sv]
// host bus master model for the register port
`timescale 1ns/1ns
module ouc_host_model
(
   input  wire logic       clk_sys,
   input  wire logic [7:0] bus_rdata,
   output logic            bus_rd,
   output logic            bus_wr,
   output logic [7:0]      bus_addr,
   output logic [7:0]      bus_wdata
);
   initial
   begin
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
   end
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
   begin
      @(negedge clk_sys);
      bus_wr = 1'b1;
      bus_addr = a;
      bus_wdata = d;
      @(negedge clk_sys);
      bus_wr = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
   end
   endtask
   // one-cycle read strobe, data taken a cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
   begin
      @(negedge clk_sys);
      bus_rd = 1'b1;
      bus_addr = a;
      @(negedge clk_sys);
      bus_rd = 1'b0;
      bus_addr = ~a;
      d = bus_rdata;
   end
   endtask
endmodule // ouc_host_model

// [test/tb_top.sv]
// self-checking bench of the global config block
`timescale 1ns/1ns
module tb_top
   import ouc_pkg::*;
;
   logic                 clk_sys;
   logic                 rst;
   logic                 bus_rd;
   logic                 bus_wr;
   logic [7:0]           bus_addr;
   logic [7:0]           bus_wdata;
   logic [7:0]           bus_rdata;
   logic [15:0]          tcnt;
   logic [7:0]           eighth;
   logic [7:0]           quarter;
   logic [7:0]           csr;
   logic [7:0]           csel;
   logic [7:0]           wsel;
   logic [3:0]           tcmd;
   logic                 tstb;
   logic                 irq;
   logic                 tmo;
   logic [7:0]           d;
   logic [7:0][7:0]      crd;
   ouc_chan_stat_t [7:0] stat;
   ouc_chan_en_t [7:0]   en;
   int                   err_count;
   int                   total_checks;

   ouc_host_model host (.clk_sys(clk_sys), .bus_rdata(bus_rdata), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata));

   ouc_global_cfg DUT (.clk_sys(clk_sys), .rst(rst), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .chan_sel(csel),
      .chan_rd(), .chan_wr(), .chan_index(), .chan_compat(), .chan_wdata(),
      .chan_rdata(crd), .chan_stat(stat), .chan_en(en), .timer_timeout(tmo),
      .timer_cmd(tcmd), .timer_cmd_stb(tstb), .timer_count(tcnt), .eighth_rate_sel(eighth),
      .quarter_rate_sel(quarter), .chan_soft_reset(csr), .sleep_enable(), .irq(irq));

   // channel select captured at each write edge
   always @(posedge clk_sys)
   begin
      if (bus_wr)
         wsel <= csel;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
   begin
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
   begin
      host.rd(a, d);
      check({8'h00, d}, {8'h00, e});
   end
   endtask
   task automatic tick(input int n);
   begin
      repeat (n) @(negedge clk_sys);
   end
   endtask
   task automatic test_done;
   begin
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial
   begin
      #100000;
      err_count++;
      test_done;
   end

   initial
   begin
      err_count = 0;
      total_checks = 0;
      rst = 1'b1;
      tmo = 1'b0;
      stat = '0;
      en = '0;
      for (int c = 0; c < 8; c++)
         crd[c] = 8'(c * 8'h11);
      tick(6);
      rst = 1'b0;
      rdchk(OFF_SUMMARY, 8'h00);
      rdchk(OFF_SRC_LOW, 8'h00);
      check({15'h0, irq}, 16'h0000);
      rdchk(OFF_IDENT, 8'hA5);
      rdchk(OFF_REVISION, 8'h01);
      rdchk(OFF_TIMER_SPR, 8'h00);
      rdchk(OFF_SOFT_RST, 8'h00);
      rdchk(8'h73, 8'h77);
      host.wr(OFF_EIGHTH, 8'h5A);
      host.wr(OFF_TCNT_LOW, 8'h34);
      host.wr(OFF_TCNT_HIGH, 8'h12);
      rdchk(OFF_EIGHTH, 8'h5A);
      check({8'h00, eighth}, 16'h005A);
      check(tcnt, 16'h1234);
      // line error on channel 1, modem change on channel 4
      en[1].line_en = 1'b1;
      en[4].modem_en = 1'b1;
      stat[1].line_err = 1'b1;
      stat[4].modem_delta = 1'b1;
      tick(1);
      stat = '0;
      tick(3);
      rdchk(OFF_SUMMARY, 8'h12);
      rdchk(OFF_SRC_LOW, 8'h08);
      rdchk(OFF_SRC_MID, 8'h40);
      check({15'h0, irq}, 16'h0001);
      host.rd(8'h15, d);
      tick(2);
      rdchk(OFF_SUMMARY, 8'h10);
      host.rd(8'h46, d);
      tick(2);
      rdchk(OFF_SUMMARY, 8'h00);
      check({15'h0, irq}, 16'h0000);
      // receive level and transmit ready together on channel 5, channel 2 masked by its enable
      en[5] = 4'hF;
      stat[5].rx_level = 1'b1;
      stat[5].tx_empty = 1'b1;
      stat[2].rx_level = 1'b1;
      tick(3);
      rdchk(OFF_SUMMARY, 8'h20);
      rdchk(OFF_SRC_MID, 8'h80);
      rdchk(OFF_SRC_HIGH, 8'h00);
      stat[5].rx_level = 1'b0;
      tick(3);
      rdchk(OFF_SRC_HIGH, 8'h01);
      host.rd(8'h52, d);
      tick(2);
      rdchk(OFF_SUMMARY, 8'h00);
      stat = '0;
      en = '0;
      // timer time-out, first masked then enabled
      tmo = 1'b1;
      tick(1);
      tmo = 1'b0;
      tick(3);
      rdchk(OFF_TIMER_CMD, 8'h00);
      host.wr(OFF_TIMER_CMD, 8'h01);
      tmo = 1'b1;
      tick(1);
      tmo = 1'b0;
      tick(3);
      rdchk(OFF_SRC_LOW, 8'h07);
      rdchk(OFF_TIMER_CMD, 8'h01);
      tick(2);
      rdchk(OFF_TIMER_CMD, 8'h00);
      rdchk(OFF_SUMMARY, 8'h00);
      // uncovered wake-up on channel 3 with all channels asleep
      host.wr(OFF_SLEEP, SLEEP_ALL);
      rdchk(OFF_SLEEP, 8'hFF);
      stat[3].wake_evt = 1'b1;
      tick(1);
      stat = '0;
      tick(3);
      rdchk(OFF_SUMMARY, 8'h08);
      rdchk(OFF_SRC_MID, 8'h00);
      host.rd(8'h32, d);
      tick(2);
      rdchk(OFF_SUMMARY, 8'h00);
      // broadcast write, plain write, rate, soft reset and timer disable
      host.wr(OFF_BCAST, 8'h01);
      host.wr(8'h03, 8'h55);
      check({8'h00, wsel}, 16'h00FF);
      host.wr(OFF_BCAST, 8'h00);
      host.wr(8'h23, 8'h55);
      check({8'h00, wsel}, 16'h0004);
      host.wr(OFF_QUARTER, 8'hC3);
      check({8'h00, quarter}, 16'h00C3);
      host.wr(OFF_SOFT_RST, 8'h81);
      check({8'h00, csr}, 16'h0081);
      tick(1);
      check({8'h00, csr}, 16'h0000);
      host.wr(OFF_TIMER_CMD, 8'h02);
      check({11'h000, tstb, tcmd}, 16'h0012);
      tmo = 1'b1;
      tick(1);
      tmo = 1'b0;
      tick(3);
      rdchk(OFF_TIMER_CMD, 8'h00);
      test_done;
   end
endmodule // tb_top
